// *** verilog/uof_pkg.sv ***
package uof_pkg;
// Operation
// - Host-mode OTG enable register has seven writable bits; bit 1 reads zero.
// - Stall flag sets when a STALL handshake is sent in a transaction.
// - Resume flag sets after K-state held 2.5 us; K depends on speed.
// - Idle flag sets after the bus stays idle 3 ms or longer.
// - Token-done flag sets per finished token; clearing it advances status FIFO.
// - Frame-start flag sets on received SOF or host SOF threshold.
// - Error summary is read-only: set only by enabled individual errors.
// - Device-mode bus-reset flag after 2.5 us reset; once per reset.
// - Host-mode attach flag: not SE0 and no activity for 2.5 us.
// - Host-mode detach flag on removal; once until reset state ends.
// - Status layout depends on mode: bits 0 and 6 differ.
// - Hardware-set flags clear only by writing one; zero leaves them. The attach flag also clears when host mode is left.
// - Flags and enables reset to zero; upper byte reads zero.
// - Each OTG enable bit gates its matching OTG status flag.
// - Each main status flag has an enable bit at the same position.

    // Clock and timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESUME_TIME_NS = 2500;
    localparam int RESET_TIME_NS = 2500;
    localparam int ATTACH_TIME_NS = 2500;
    localparam int IDLE_TIME_MS = 3;
    localparam int RESUME_CYCLES = (RESUME_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ATTACH_CYCLES = (ATTACH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_CYCLES = (IDLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register map, byte addresses
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] OFS_MAIN_STATUS = 8'h00;
    localparam logic [7:0] OFS_MAIN_ENABLE = 8'h04;
    localparam logic [7:0] OFS_OTG_STATUS = 8'h08;
    localparam logic [7:0] OFS_OTG_ENABLE = 8'h0c;

    // Main status bit positions
    localparam int BIT_STALL = 7;
    localparam int BIT_ATTACH = 6;
    localparam int BIT_RESUME = 5;
    localparam int BIT_IDLE = 4;
    localparam int BIT_TOKEN = 3;
    localparam int BIT_SOF = 2;
    localparam int BIT_ERROR = 1;
    localparam int BIT_RESET_DETACH = 0;

    // Field masks and reset values
    localparam logic [7:0] MAIN_HOST_MASK = 8'hff;
    localparam logic [7:0] MAIN_DEVICE_MASK = 8'hbf;
    localparam logic [7:0] MAIN_W1C_MASK = 8'hfd;
    localparam logic [7:0] OTG_MASK = 8'hfd;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] UPPER_BYTE = 8'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Line pins and bus-engine events
    typedef struct packed {
        logic dp;
        logic dm;
        logic low_speed;
        logic activity;
    } uof_line_s;

    typedef struct packed {
        logic stall_sent;
        logic token_done;
        logic frame_start;
    } uof_events_s;
endpackage

// *** verilog/uof_stretch.sv ***
`timescale 1ns/1ps
module uof_stretch #(
    parameter int CYCLES = 100
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Condition and one-shot result
    input wire logic cond,
    output logic fire
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
        logic fire;
    } uof_stretch_s;

    uof_stretch_s q_reg;
    uof_stretch_s q_next;

    // Fires once per unbroken stretch; re-arms only when cond drops
    always_comb begin
        q_next = q_reg;
        q_next.fire = 1'b0;
        if (!cond) begin
            q_next.cnt = '0;
            q_next.done = 1'b0;
        end else if (!q_reg.done) begin
            if (q_reg.cnt == LAST) begin
                q_next.done = 1'b1;
                q_next.fire = 1'b1;
            end else begin
                q_next.cnt = q_reg.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign fire = q_reg.fire;
endmodule

// *** verilog/uof_top.sv ***
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module uof_top #(
    parameter int IDLE_CYCLES = uof_pkg::IDLE_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [uof_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [uof_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Mode and bus state
    input wire logic host_mode,
    input wire uof_pkg::uof_line_s line,
    input wire uof_pkg::uof_events_s events,
    // OTG event pulses, bit 1 unused
    input wire logic [7:0] otg_events,
    // Individual error flags and their enables from the error block
    input wire logic [7:0] error_flags,
    input wire logic [7:0] error_enables,
    // Interrupt and token status FIFO
    output logic irq,
    output logic stat_fifo_advance
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic aw_held;
        logic w_held;
        logic [7:0] aw_addr;
        logic [7:0] wdata;
        logic wlane;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [15:0] rdata;
        logic [7:0] main_flags;
        logic [7:0] main_en;
        logic [7:0] otg_flags;
        logic [7:0] otg_en;
        logic err_sum;
        logic [1:0] line_prev;
        logic irq;
        logic fifo_adv;
    } uof_state_s;

    // Readies start high so a request right after reset is taken at once
    localparam uof_state_s RESET_STATE = '{
        awready: 1'b1,
        wready: 1'b1,
        bvalid: 1'b0,
        bresp: uof_pkg::RESP_OKAY,
        aw_held: 1'b0,
        w_held: 1'b0,
        aw_addr: 8'h00,
        wdata: 8'h00,
        wlane: 1'b0,
        arready: 1'b1,
        rvalid: 1'b0,
        rresp: uof_pkg::RESP_OKAY,
        rdata: 16'h0000,
        main_flags: uof_pkg::REG_RESET,
        main_en: uof_pkg::REG_RESET,
        otg_flags: uof_pkg::REG_RESET,
        otg_en: uof_pkg::REG_RESET,
        err_sum: 1'b0,
        line_prev: 2'h0,
        irq: 1'b0,
        fifo_adv: 1'b0
    };

    uof_state_s q_reg;
    uof_state_s q_next;

    logic se0;
    logic j_state;
    logic k_state;
    logic line_moved;
    logic resume_fire;
    logic idle_fire;
    logic se0_fire;
    logic attach_fire;
    logic aw_take;
    logic w_take;
    logic wr_go;
    logic b_done;
    logic ar_take;
    logic r_done;

    // Handshake strobes; a write commits only once both halves are held
    always_comb begin
        aw_take = s_axi_awvalid && q_reg.awready;
        w_take = s_axi_wvalid && q_reg.wready;
        wr_go = q_reg.aw_held && q_reg.w_held && !q_reg.bvalid;
        b_done = q_reg.bvalid && s_axi_bready;
        ar_take = s_axi_arvalid && q_reg.arready;
        r_done = q_reg.rvalid && s_axi_rready;
    end

    // Line decode; J and K swap polarity at low speed
    always_comb begin
        se0 = !line.dp && !line.dm;
        j_state = line.low_speed ? (!line.dp && line.dm) : (line.dp && !line.dm);
        k_state = line.low_speed ? (line.dp && !line.dm) : (!line.dp && line.dm);
        line_moved = {line.dp, line.dm} != q_reg.line_prev;
    end

    uof_stretch #(
        .CYCLES(uof_pkg::RESUME_CYCLES)
    ) u_resume (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond(k_state),
        .fire(resume_fire)
    );

    // Idle means J held with no activity seen
    uof_stretch #(
        .CYCLES(IDLE_CYCLES)
    ) u_idle (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond(j_state && !line.activity),
        .fire(idle_fire)
    );

    // One SE0 stretch gives one bus reset or one detach, never a repeat
    uof_stretch #(
        .CYCLES(uof_pkg::RESET_CYCLES)
    ) u_se0 (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond(se0),
        .fire(se0_fire)
    );

    uof_stretch #(
        .CYCLES(uof_pkg::ATTACH_CYCLES)
    ) u_attach (
        .aclk(aclk),
        .aresetn(aresetn),
        .cond(host_mode && !se0 && !line.activity && !line_moved),
        .fire(attach_fire)
    );

    logic [7:0] mode_mask;
    logic [7:0] set_main;
    logic [7:0] clr_main;
    logic [7:0] clr_otg;
    logic [7:0] main_view;
    logic [7:0] next_view;

    always_comb begin
        q_next = q_reg;
        q_next.fifo_adv = 1'b0;
        q_next.line_prev = {line.dp, line.dm};
        clr_main = 8'h00;
        clr_otg = 8'h00;
        mode_mask = host_mode ? uof_pkg::MAIN_HOST_MASK : uof_pkg::MAIN_DEVICE_MASK;

        // Address and data may come in either order
        if (aw_take) begin
            q_next.aw_held = 1'b1;
            q_next.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            q_next.w_held = 1'b1;
            q_next.wdata = s_axi_wdata[7:0];
            q_next.wlane = s_axi_wstrb[0];
        end
        if (wr_go) begin
            q_next.aw_held = 1'b0;
            q_next.w_held = 1'b0;
            q_next.bvalid = 1'b1;
            q_next.bresp = uof_pkg::RESP_OKAY;
            case (q_reg.aw_addr)
                uof_pkg::OFS_MAIN_STATUS: begin
                    if (q_reg.wlane) begin
                        clr_main = q_reg.wdata & uof_pkg::MAIN_W1C_MASK;
                    end
                end
                uof_pkg::OFS_MAIN_ENABLE: begin
                    if (q_reg.wlane) begin
                        q_next.main_en = q_reg.wdata;
                    end
                end
                uof_pkg::OFS_OTG_STATUS: begin
                    if (q_reg.wlane) begin
                        clr_otg = q_reg.wdata & uof_pkg::OTG_MASK;
                    end
                end
                uof_pkg::OFS_OTG_ENABLE: begin
                    if (q_reg.wlane) begin
                        q_next.otg_en = q_reg.wdata & uof_pkg::OTG_MASK;
                    end
                end
                default: begin
                    q_next.bresp = uof_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (b_done) begin
            q_next.bvalid = 1'b0;
        end
        q_next.awready = !q_next.aw_held && !q_next.bvalid;
        q_next.wready = !q_next.w_held && !q_next.bvalid;

        // Hardware sets
        set_main = 8'h00;
        set_main[uof_pkg::BIT_STALL] = events.stall_sent;
        set_main[uof_pkg::BIT_ATTACH] = attach_fire;
        set_main[uof_pkg::BIT_RESUME] = resume_fire;
        set_main[uof_pkg::BIT_IDLE] = idle_fire;
        set_main[uof_pkg::BIT_TOKEN] = events.token_done;
        set_main[uof_pkg::BIT_SOF] = events.frame_start;
        set_main[uof_pkg::BIT_RESET_DETACH] = se0_fire;

        // Set wins over a clear in the same cycle
        q_next.main_flags = ((q_reg.main_flags & ~clr_main) | set_main)
            & mode_mask & uof_pkg::MAIN_W1C_MASK;
        q_next.otg_flags = ((q_reg.otg_flags & ~clr_otg) | otg_events)
            & uof_pkg::OTG_MASK;
        q_next.fifo_adv = clr_main[uof_pkg::BIT_TOKEN]
            && q_reg.main_flags[uof_pkg::BIT_TOKEN];

        // Masked errors never reach the summary
        q_next.err_sum = |(error_flags & error_enables);

        main_view = {q_reg.main_flags[7:2], q_reg.err_sum, q_reg.main_flags[0]};
        next_view = {q_next.main_flags[7:2], q_next.err_sum, q_next.main_flags[0]};
        q_next.irq = |(next_view & q_next.main_en & mode_mask)
            || |(q_next.otg_flags & q_next.otg_en);

        // Read path: one outstanding read, data from the pre-edge state
        if (ar_take) begin
            q_next.arready = 1'b0;
            q_next.rvalid = 1'b1;
            q_next.rresp = uof_pkg::RESP_OKAY;
            case (s_axi_araddr)
                uof_pkg::OFS_MAIN_STATUS: begin
                    q_next.rdata = {uof_pkg::UPPER_BYTE, main_view & mode_mask};
                end
                uof_pkg::OFS_MAIN_ENABLE: begin
                    q_next.rdata = {uof_pkg::UPPER_BYTE, q_reg.main_en & mode_mask};
                end
                uof_pkg::OFS_OTG_STATUS: begin
                    q_next.rdata = {uof_pkg::UPPER_BYTE, q_reg.otg_flags};
                end
                uof_pkg::OFS_OTG_ENABLE: begin
                    q_next.rdata = {uof_pkg::UPPER_BYTE, q_reg.otg_en};
                end
                default: begin
                    q_next.rdata = 16'h0000;
                    q_next.rresp = uof_pkg::RESP_SLVERR;
                end
            endcase
        end else if (r_done) begin
            q_next.rvalid = 1'b0;
            q_next.arready = 1'b1;
        end
    end

    // Protection bits are accepted but carry no meaning here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_reg <= RESET_STATE;
        end else begin
            q_reg <= q_next;
        end
    end

    assign s_axi_awready = q_reg.awready;
    assign s_axi_wready = q_reg.wready;
    assign s_axi_bvalid = q_reg.bvalid;
    assign s_axi_bresp = q_reg.bresp;
    assign s_axi_arready = q_reg.arready;
    assign s_axi_rvalid = q_reg.rvalid;
    assign s_axi_rdata = {16'h0000, q_reg.rdata};
    assign s_axi_rresp = q_reg.rresp;
    assign irq = q_reg.irq;
    assign stat_fifo_advance = q_reg.fifo_adv;
endmodule

// *** dv/uof_top_sva.sv ***
`timescale 1ns/1ps
module uof_top_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // Causes and results
    input wire logic host_mode,
    input wire logic [7:0] error_flags,
    input wire logic [7:0] error_enables,
    input wire logic irq,
    input wire logic stat_fifo_advance
);
    logic host_q;
    logic [3:0] hist;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Error level and mode swap may drop irq without a write
    always_ff @(posedge aclk) begin
        host_q <= host_mode;
        hist <= {hist[2:0], (|(error_flags & error_enables)) || host_q != host_mode};
    end
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !irq && !s_axi_rvalid)
        else $error("outputs active after reset");
    a_advance_write: assert property (stat_fifo_advance |-> $rose(s_axi_bvalid))
        else $error("fifo advance without write");
    a_advance_single: assert property (stat_fifo_advance |=> !stat_fifo_advance)
        else $error("fifo advance too long");
    a_irq_drop_cause: assert property ($fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid)
        || hist != 4'h0) else $error("irq dropped without clear");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
        && !s_axi_arready) else $error("read answer late");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
    cover property (stat_fifo_advance);
    cover property ($rose(irq));
    cover property (s_axi_rvalid && s_axi_rdata[6]);
endmodule
bind uof_top uof_top_sva u_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rdata, .host_mode, .error_flags, .error_enables, .irq,
    .stat_fifo_advance);

// *** dv/uof_bus_model.sv ***
`timescale 1ns/1ps
module uof_bus_model (
    // Clock
    input wire logic aclk,
    // Requested state: 0 J, 1 K, 2 SE0, 3 traffic
    input wire logic [1:0] bus_state,
    input wire logic low_speed,
    input wire uof_pkg::uof_events_s pulse,
    // Toward the block
    output uof_pkg::uof_line_s line,
    output uof_pkg::uof_events_s events
);
    logic tgl = 1'b0;
    always @(posedge aclk) begin
        tgl <= ~tgl;
        events <= pulse;
        line.low_speed <= low_speed;
        line.activity <= bus_state == 2'h3;
        case (bus_state)
            2'h0: {line.dp, line.dm} <= low_speed ? 2'b01 : 2'b10;
            2'h1: {line.dp, line.dm} <= low_speed ? 2'b10 : 2'b01;
            2'h2: {line.dp, line.dm} <= 2'b00;
            // Traffic flips J and K so no timer can mature
            default: {line.dp, line.dm} <= {tgl, ~tgl};
        endcase
    end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    localparam logic [7:0] ST = uof_pkg::OFS_MAIN_STATUS;
    localparam logic [7:0] EN = uof_pkg::OFS_MAIN_ENABLE;
    localparam logic [7:0] OS = uof_pkg::OFS_OTG_STATUS;
    localparam logic [7:0] OE = uof_pkg::OFS_OTG_ENABLE;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp, bus_state = 2'h3;
    logic host_mode = 1'b0, low_speed = 1'b0, irq, stat_fifo_advance;
    logic [7:0] otg_events = 8'h00, error_flags = 8'h00, error_enables = 8'h00;
    uof_pkg::uof_events_s pulse = 3'h0;
    uof_pkg::uof_events_s events;
    uof_pkg::uof_line_s line;
    int n_errors = 0;
    int compares = 0;
    int n_adv = 0;
    always #12.5 aclk = ~aclk;
    // Counts advance pulses so a one-cycle pulse is never missed
    always @(posedge aclk) if (stat_fifo_advance === 1'b1) n_adv++;
    uof_bus_model u_bus (.aclk, .bus_state, .low_speed, .pulse, .line, .events);
    uof_top #(.IDLE_CYCLES(200)) u_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb(4'hf), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .host_mode, .line, .events, .otg_events, .error_flags,
        .error_enables, .irq, .stat_fifo_advance);
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        got = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk($sformatf("reg %h", a), e, got & m);
    endtask
    task automatic fire(input uof_pkg::uof_events_s p, input logic [7:0] o);
        @(posedge aclk);
        pulse <= p;
        otg_events <= o;
        @(posedge aclk);
        pulse <= 3'h0;
        otg_events <= 8'h00;
        cyc(2);
    endtask
    task automatic t_regs();
        for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'hffffffff, 32'h0);
        rd(8'h10, 32'hffffffff, 32'h0);
        chk("unmapped read", 32'(uof_pkg::RESP_SLVERR), 32'(resp));
        wr(8'h10, 32'hff);
        chk("unmapped write", 32'(uof_pkg::RESP_SLVERR), 32'(resp));
        wr(OE, 32'hffffffff);
        rd(OE, 32'hffffffff, 32'hfd);
        wr(EN, 32'hffffffff);
        rd(EN, 32'hffffffff, 32'hbf);
        @(posedge aclk) host_mode <= 1'b1;
        rd(EN, 32'hffffffff, 32'hff);
        @(posedge aclk) host_mode <= 1'b0;
        $display("test regs done");
    endtask
    task automatic t_events();
        int adv0;
        chk("irq quiet", 32'h0, 32'(irq));
        fire(3'h7, 8'hff);
        rd(ST, 32'hffffffff, 32'h8c);
        rd(OS, 32'hffffffff, 32'hfd);
        chk("irq raised", 32'h1, 32'(irq));
        wr(ST, 32'h0);
        rd(ST, 32'hff, 32'h8c);
        adv0 = n_adv;
        wr(ST, 32'h08);
        cyc(1);
        chk("fifo advance", 32'h1, 32'(n_adv - adv0));
        rd(ST, 32'hff, 32'h84);
        wr(OS, 32'hff);
        wr(ST, 32'h84);
        cyc(2);
        chk("no fifo advance", 32'h1, 32'(n_adv - adv0));
        chk("irq cleared", 32'h0, 32'(irq));
        wr(EN, 32'h7f);
        wr(OE, 32'h7d);
        fire(3'h4, 8'h80);
        rd(ST, 32'hff, 32'h80);
        chk("irq masked", 32'h0, 32'(irq));
        wr(OE, 32'hfd);
        cyc(2);
        chk("irq otg", 32'h1, 32'(irq));
        wr(OS, 32'hff);
        wr(EN, 32'hff);
        cyc(2);
        chk("irq main", 32'h1, 32'(irq));
        wr(ST, 32'hff);
        $display("test events done");
    endtask
    task automatic t_error();
        @(posedge aclk) error_flags <= 8'h04;
        cyc(4);
        rd(ST, 32'h02, 32'h0);
        @(posedge aclk) error_enables <= 8'h04;
        cyc(4);
        rd(ST, 32'h02, 32'h02);
        chk("irq error", 32'h1, 32'(irq));
        wr(ST, 32'h02);
        rd(ST, 32'h02, 32'h02);
        @(posedge aclk) error_flags <= 8'h00;
        cyc(4);
        rd(ST, 32'h02, 32'h0);
        $display("test error done");
    endtask
    task automatic t_timers();
        for (int s = 0; s < 2; s++) begin
            @(posedge aclk) low_speed <= s[0];
            bus_state <= 2'h1;
            cyc(90);
            rd(ST, 32'h20, 32'h0);
            cyc(10);
            rd(ST, 32'h20, 32'h20);
            @(posedge aclk) bus_state <= 2'h2;
            host_mode <= s[0];
            wr(ST, 32'hff);
            cyc(110);
            rd(ST, 32'h01, 32'h01);
            wr(ST, 32'h01);
            cyc(110);
            rd(ST, 32'h01, 32'h0);
            @(posedge aclk) bus_state <= 2'h3;
        end
        @(posedge aclk) bus_state <= 2'h0;
        cyc(110);
        rd(ST, 32'h50, 32'h40);
        cyc(100);
        rd(ST, 32'h10, 32'h10);
        @(posedge aclk) host_mode <= 1'b0;
        rd(ST, 32'h40, 32'h0);
        @(posedge aclk) bus_state <= 2'h3;
        $display("test timers done");
    endtask
    initial begin
        #250000;
        n_errors++;
        test_done();
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_events();
        t_error();
        t_timers();
        test_done();
    end
endmodule
